//--- core/fcsi_pkg.sv
/*
 Shared constants and types of the flash command host: device command
 codes, status fields, host register map, timing and the pin carriers.
 Assumes one 40 MHz system clock and a byte-wide flash on the pins.
*/
package fcsi_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_ACC_NS      = 85;
   localparam int T_WP_NS       = 50;
   localparam int SYNC_LAT      = 5;
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC_RAW = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC = (WP_CYC_RAW < 1) ? 1 : WP_CYC_RAW;
   // Read wait covers access time plus the input synchroniser
   localparam int RD_CYC  = ACC_CYC + SYNC_LAT;

   // ==========================================================
   // Device commands
   localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
   localparam logic [7:0] CMD_READ_ID       = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
   localparam logic [7:0] CMD_CONFIRM       = 8'hd0;
   localparam logic [7:0] CMD_SUSPEND       = 8'hb0;
   localparam logic [7:0] CMD_PROG_SETUP    = 8'h40;
   localparam logic [7:0] CMD_PROG_SETUP_2  = 8'h10;
   localparam logic [19:0] ID_MAKER_ADDR    = 20'h00000;
   localparam logic [19:0] ID_PART_ADDR     = 20'h00001;

   // ==========================================================
   // Device status word fields
   localparam int ST_ENGINE_READY  = 7;
   localparam int ST_ERASE_SUSP    = 6;
   localparam int ST_ERASE_ERR     = 5;
   localparam int ST_PROG_ERR      = 4;
   localparam int ST_SUPPLY_LOW    = 3;

   // ==========================================================
   // Host register map, reset values and interrupt bits
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_ADDR     = 4'h1;
   localparam logic [3:0] REG_DATA     = 4'h2;
   localparam logic [3:0] REG_RESULT   = 4'h3;
   localparam logic [3:0] REG_ID       = 4'h4;
   localparam logic [3:0] REG_STATUS   = 4'h5;
   localparam logic [3:0] REG_IRQ_STAT = 4'h6;
   localparam logic [3:0] REG_IRQ_MASK = 4'h7;
   localparam logic [3:0] REG_SUPPLY   = 4'h8;
   localparam int CTRL_ALT_BIT = 4;
   localparam int IRQ_DONE     = 0;
   localparam int IRQ_DEV_ERR  = 1;
   localparam int IRQ_REJECT   = 2;
   localparam int IRQ_W        = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   localparam logic [7:0] DEV_STATUS_RST     = 8'h80;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      OP_READ_ARRAY   = 4'h0,
      OP_READ_ID      = 4'h1,
      OP_READ_STATUS  = 4'h2,
      OP_CLEAR_STATUS = 4'h3,
      OP_ERASE        = 4'h4,
      OP_SUSPEND      = 4'h5,
      OP_RESUME       = 4'h6,
      OP_PROGRAM      = 4'h7
   } fcsi_op_e;

   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_WSET  = 3'h1,
      S_WLOW  = 3'h2,
      S_WHOLD = 3'h3,
      S_RSET  = 3'h4,
      S_RLOW  = 3'h5,
      S_RCAP  = 3'h6,
      S_NEXT  = 3'h7
   } fcsi_state_e;

   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  dq_o;
      logic        dq_oe_n;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
   } fcsi_pins_s;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } fcsi_bus_s;

   localparam fcsi_pins_s PINS_RST = '{addr: 20'h00000, dq_o: 8'h00,
      dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
endpackage

//--- core/fcsi_sync.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module fcsi_sync #(
   parameter int W = 8
)(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   if (W < 1) begin : g_chk
      $error("fcsi_sync: W must be at least 1");
   end

   // ==========================================================
   // Stages; only stage two reads stage one
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts only once stages two and three agree
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (s2_q == s3_q) begin
         q <= s3_q;
      end
   end
endmodule

//--- core/fcsi_timer.sv
/*
 Loadable down counter that times strobe widths.
 Assumes load values fit in W bits.
*/
`timescale 1ns/1ps
module fcsi_timer #(
   parameter int W = 4
)(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              done
);
   logic [W-1:0] cnt_q;

   if (W < 1 || W > 16) begin : g_chk
      $error("fcsi_timer: W out of range");
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= value;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign done = (cnt_q == '0) && !load;
endmodule

//--- core/fcsi_host.sv
/*
 Host-side controller for a byte-wide flash with a command interface.
 Software starts one operation at a time through a small register port;
 the controller runs the bus cycles on the flash pins and reports back.
 Assumes the flash is strobe driven and asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module fcsi_host (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire fcsi_pkg::fcsi_bus_s sw,
   output logic [31:0]              sw_rdata,
   output logic                     irq,
   output fcsi_pkg::fcsi_pins_s     flash,
   input  wire logic [7:0]          flash_dq_in,
   output logic                     supply_high_en
);
   localparam int TW = 4;

   fcsi_pkg::fcsi_state_e state_q;
   fcsi_pkg::fcsi_state_e state_d;
   fcsi_pkg::fcsi_op_e    op_q;
   logic [1:0]            step_q;
   logic                  alt_q;
   logic [19:0]           addr_q;
   logic [7:0]            data_q;
   logic [7:0]            result_q;
   logic [7:0]            maker_q;
   logic [7:0]            part_q;
   logic [7:0]            dev_status_q;
   logic [fcsi_pkg::IRQ_W-1:0] stat_q;
   logic [fcsi_pkg::IRQ_W-1:0] mask_q;
   logic [fcsi_pkg::IRQ_W-1:0] stat_set;
   logic                  supply_q;
   logic [7:0]            dq_sync;
   logic                  tmr_load;
   logic [TW-1:0]         tmr_val;
   logic                  tmr_done;
   logic                  ctrl_wr;
   logic                  op_valid;
   logic                  needs_supply;
   logic                  start_ok;
   logic                  busy;
   logic                  fin;
   logic                  nxt_wr;
   logic [7:0]            plan_byte;
   logic [19:0]           plan_addr;
   logic [7:0]            first_code;

   if (fcsi_pkg::RD_CYC >= (1 << TW) || fcsi_pkg::WP_CYC >= (1 << TW)) begin : g_chk
      $error("fcsi_host: timer too narrow for strobe counts");
   end

   fcsi_sync #(.W(8)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (flash_dq_in),
      .q       (dq_sync)
   );

   fcsi_timer #(.W(TW)) u_tmr (
      .clk_sys (clk_sys),
      .rst     (rst),
      .load    (tmr_load),
      .value   (tmr_val),
      .done    (tmr_done)
   );

   // ==========================================================
   // Operation acceptance
   assign busy     = (state_q != fcsi_pkg::S_IDLE);
   assign ctrl_wr  = sw.we && (sw.addr == fcsi_pkg::REG_CTRL);
   assign op_valid = (sw.wdata[3:0] <= fcsi_pkg::OP_PROGRAM);
   assign needs_supply = (sw.wdata[3:0] == fcsi_pkg::OP_ERASE) ||
                         (sw.wdata[3:0] == fcsi_pkg::OP_PROGRAM) ||
                         (sw.wdata[3:0] == fcsi_pkg::OP_RESUME);
   assign start_ok = ctrl_wr && !busy && op_valid && (supply_q || !needs_supply);

   // ==========================================================
   // Bus cycle plan for the current step
   always_comb begin
      first_code = fcsi_pkg::CMD_READ_ARRAY;
      unique case (op_q)
         fcsi_pkg::OP_READ_ARRAY:   first_code = fcsi_pkg::CMD_READ_ARRAY;
         fcsi_pkg::OP_READ_ID:      first_code = fcsi_pkg::CMD_READ_ID;
         fcsi_pkg::OP_READ_STATUS:  first_code = fcsi_pkg::CMD_READ_STATUS;
         fcsi_pkg::OP_CLEAR_STATUS: first_code = fcsi_pkg::CMD_CLEAR_STATUS;
         fcsi_pkg::OP_ERASE:        first_code = fcsi_pkg::CMD_ERASE_SETUP;
         fcsi_pkg::OP_SUSPEND:      first_code = fcsi_pkg::CMD_SUSPEND;
         fcsi_pkg::OP_RESUME:       first_code = fcsi_pkg::CMD_CONFIRM;
         fcsi_pkg::OP_PROGRAM:
            first_code = alt_q ? fcsi_pkg::CMD_PROG_SETUP_2 : fcsi_pkg::CMD_PROG_SETUP;
      endcase
   end

   always_comb begin
      plan_byte = first_code;
      if (step_q != 2'd0) begin
         plan_byte = (op_q == fcsi_pkg::OP_ERASE) ? fcsi_pkg::CMD_CONFIRM : data_q;
      end
   end

   // Erase and program keep the target address on both writes; identifier reads use the fixed ID addresses
   always_comb begin
      plan_addr = addr_q;
      if (op_q == fcsi_pkg::OP_READ_ID && step_q == 2'd1) begin
         plan_addr = fcsi_pkg::ID_MAKER_ADDR;
      end else if (op_q == fcsi_pkg::OP_READ_ID && step_q == 2'd2) begin
         plan_addr = fcsi_pkg::ID_PART_ADDR;
      end
   end

   assign nxt_wr = (step_q == 2'd0) &&
                   (op_q == fcsi_pkg::OP_ERASE || op_q == fcsi_pkg::OP_PROGRAM);

   // Polling leans on the flash answering status without a fresh status command
   always_comb begin
      fin = 1'b0;
      unique case (op_q)
         fcsi_pkg::OP_READ_ARRAY,
         fcsi_pkg::OP_READ_STATUS:  fin = (step_q == 2'd1);
         fcsi_pkg::OP_READ_ID:      fin = (step_q == 2'd2);
         fcsi_pkg::OP_CLEAR_STATUS,
         fcsi_pkg::OP_RESUME:       fin = 1'b1;
         fcsi_pkg::OP_ERASE,
         fcsi_pkg::OP_PROGRAM:
            fin = (step_q == 2'd2) && dev_status_q[fcsi_pkg::ST_ENGINE_READY];
         fcsi_pkg::OP_SUSPEND:
            fin = (step_q != 2'd0) && dev_status_q[fcsi_pkg::ST_ENGINE_READY];
      endcase
   end

   // ==========================================================
   // Sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         fcsi_pkg::S_IDLE:  if (start_ok) state_d = fcsi_pkg::S_WSET;
         fcsi_pkg::S_WSET:  state_d = fcsi_pkg::S_WLOW;
         fcsi_pkg::S_WLOW:  if (tmr_done) state_d = fcsi_pkg::S_WHOLD;
         fcsi_pkg::S_WHOLD: state_d = fcsi_pkg::S_NEXT;
         fcsi_pkg::S_RSET:  state_d = fcsi_pkg::S_RLOW;
         fcsi_pkg::S_RLOW:  if (tmr_done) state_d = fcsi_pkg::S_RCAP;
         fcsi_pkg::S_RCAP:  state_d = fcsi_pkg::S_NEXT;
         fcsi_pkg::S_NEXT: begin
            if (fin) begin
               state_d = fcsi_pkg::S_IDLE;
            end else begin
               state_d = nxt_wr ? fcsi_pkg::S_WSET : fcsi_pkg::S_RSET;
            end
         end
      endcase
   end

   assign tmr_load = (state_d != state_q) &&
                     (state_d == fcsi_pkg::S_WLOW || state_d == fcsi_pkg::S_RLOW);
   assign tmr_val  = (state_d == fcsi_pkg::S_WLOW) ? TW'(fcsi_pkg::WP_CYC - 1) :
                                                     TW'(fcsi_pkg::RD_CYC - 1);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= fcsi_pkg::S_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         op_q   <= fcsi_pkg::OP_READ_ARRAY;
         step_q <= 2'd0;
      end else if (start_ok) begin
         op_q   <= fcsi_pkg::fcsi_op_e'(sw.wdata[3:0]);
         step_q <= 2'd0;
      end else if (state_q == fcsi_pkg::S_NEXT) begin
         step_q <= fin ? 2'd0 : ((step_q == 2'd2) ? 2'd2 : step_q + 2'd1);
      end
   end

   // ==========================================================
   // Pins; address and data follow the plan every cycle, one cycle late,
   // so a new step's values land on the same edge as its strobe falls
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flash <= fcsi_pkg::PINS_RST;
      end else begin
         flash.addr    <= plan_addr;
         flash.dq_o    <= plan_byte;
         flash.dq_oe_n <= !(state_d == fcsi_pkg::S_WSET || state_d == fcsi_pkg::S_WLOW ||
                            state_d == fcsi_pkg::S_WHOLD);
         flash.ce_n    <= !(state_d == fcsi_pkg::S_WSET || state_d == fcsi_pkg::S_WLOW ||
                            state_d == fcsi_pkg::S_WHOLD || state_d == fcsi_pkg::S_RLOW);
         flash.we_n    <= (state_d != fcsi_pkg::S_WLOW);
         flash.oe_n    <= (state_d != fcsi_pkg::S_RLOW);
      end
   end

   // ==========================================================
   // Read capture
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         result_q     <= 8'h00;
         maker_q      <= 8'h00;
         part_q       <= 8'h00;
         dev_status_q <= fcsi_pkg::DEV_STATUS_RST;
      end else if (state_q == fcsi_pkg::S_RCAP) begin
         result_q <= dq_sync;
         if (op_q == fcsi_pkg::OP_READ_ID) begin
            if (step_q == 2'd1) maker_q <= dq_sync;
            else part_q <= dq_sync;
         end else if (op_q != fcsi_pkg::OP_READ_ARRAY) begin
            dev_status_q <= dq_sync;
         end
      end else if (state_q == fcsi_pkg::S_NEXT && op_q == fcsi_pkg::OP_CLEAR_STATUS) begin
         // Shadow follows the flash, which drops its error bits on clear
         dev_status_q[fcsi_pkg::ST_ERASE_ERR:fcsi_pkg::ST_SUPPLY_LOW] <= 3'h0;
      end
   end

   // ==========================================================
   // Software registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         alt_q    <= 1'b0;
         addr_q   <= 20'h00000;
         data_q   <= 8'h00;
         mask_q   <= fcsi_pkg::IRQ_MASK_RST;
         supply_q <= 1'b0;
      end else if (sw.we) begin
         // Operands are frozen while an operation runs
         if (sw.addr == fcsi_pkg::REG_ADDR && !busy) addr_q <= sw.wdata[19:0];
         if (sw.addr == fcsi_pkg::REG_DATA && !busy) data_q <= sw.wdata[7:0];
         if (start_ok) alt_q <= sw.wdata[fcsi_pkg::CTRL_ALT_BIT];
         if (sw.addr == fcsi_pkg::REG_IRQ_MASK) mask_q <= sw.wdata[fcsi_pkg::IRQ_W-1:0];
         if (sw.addr == fcsi_pkg::REG_SUPPLY) supply_q <= sw.wdata[0];
      end
   end

   always_comb begin
      stat_set = '0;
      stat_set[fcsi_pkg::IRQ_DONE]   = (state_q == fcsi_pkg::S_NEXT) && fin;
      stat_set[fcsi_pkg::IRQ_DEV_ERR] = (state_q == fcsi_pkg::S_NEXT) && fin &&
         (op_q == fcsi_pkg::OP_ERASE || op_q == fcsi_pkg::OP_PROGRAM) &&
         (dev_status_q[fcsi_pkg::ST_ERASE_ERR] || dev_status_q[fcsi_pkg::ST_PROG_ERR] ||
          dev_status_q[fcsi_pkg::ST_SUPPLY_LOW]);
      stat_set[fcsi_pkg::IRQ_REJECT] = ctrl_wr && !start_ok;
   end

   // A set in the cycle of the clearing read survives
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stat_q <= '0;
      end else if (sw.re && sw.addr == fcsi_pkg::REG_IRQ_STAT) begin
         stat_q <= stat_set;
      end else begin
         stat_q <= stat_q | stat_set;
      end
   end

   assign irq = |(stat_q & mask_q);
   assign supply_high_en = supply_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sw_rdata <= 32'h00000000;
      end else if (!sw.re) begin
         sw_rdata <= 32'h00000000;
      end else begin
         unique case (sw.addr)
            fcsi_pkg::REG_CTRL:     sw_rdata <= {27'h0, alt_q, op_q};
            fcsi_pkg::REG_ADDR:     sw_rdata <= {12'h0, addr_q};
            fcsi_pkg::REG_DATA:     sw_rdata <= {24'h0, data_q};
            fcsi_pkg::REG_RESULT:   sw_rdata <= {24'h0, result_q};
            fcsi_pkg::REG_ID:       sw_rdata <= {16'h0, part_q, maker_q};
            fcsi_pkg::REG_STATUS:   sw_rdata <= {23'h0, busy, dev_status_q};
            fcsi_pkg::REG_IRQ_STAT: sw_rdata <= {29'h0, stat_q};
            fcsi_pkg::REG_IRQ_MASK: sw_rdata <= {29'h0, mask_q};
            fcsi_pkg::REG_SUPPLY:   sw_rdata <= {31'h0, supply_q};
            default:                sw_rdata <= 32'h00000000;
         endcase
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_we_pulse;
      (!flash.we_n) [*2] ##1 flash.we_n;
   endsequence

   sequence s_erase_setup;
      $rose(flash.we_n) && flash.dq_o == fcsi_pkg::CMD_ERASE_SETUP;
   endsequence

   sequence s_erase_confirm;
      $rose(flash.we_n) && flash.dq_o == fcsi_pkg::CMD_CONFIRM && !flash.ce_n;
   endsequence

   a_we_in_select: assert property (!flash.we_n |-> !flash.ce_n && flash.oe_n)
      else $error("write strobe low outside chip select");
   a_we_pulse_len: assert property ($fell(flash.we_n) |-> s_we_pulse)
      else $error("write strobe width wrong");
   a_latch_stable: assert property ($rose(flash.we_n) |->
         $stable(flash.addr) && $stable(flash.dq_o) && !flash.dq_oe_n)
      else $error("address or data moved at strobe rise");
   a_erase_pair: assert property (s_erase_setup |-> ##[4:6] s_erase_confirm)
      else $error("erase setup not followed by confirm");
   a_erase_block: assert property ($rose(flash.we_n) && op_q == fcsi_pkg::OP_ERASE |->
         flash.addr == addr_q)
      else $error("erase write outside target address");
   a_prog_setup: assert property ($rose(flash.we_n) && op_q == fcsi_pkg::OP_PROGRAM &&
         step_q == 2'd0 |-> flash.dq_o == fcsi_pkg::CMD_PROG_SETUP ||
         flash.dq_o == fcsi_pkg::CMD_PROG_SETUP_2)
      else $error("bad program setup code");
   a_array_cmd: assert property ($rose(flash.we_n) && op_q == fcsi_pkg::OP_READ_ARRAY |->
         flash.dq_o == fcsi_pkg::CMD_READ_ARRAY)
      else $error("array read without array command");
   a_id_address: assert property (!flash.oe_n && op_q == fcsi_pkg::OP_READ_ID |->
         flash.addr == ((step_q == 2'd2) ? fcsi_pkg::ID_PART_ADDR : fcsi_pkg::ID_MAKER_ADDR))
      else $error("identifier read at wrong address");
   a_supply_gate: assert property (ctrl_wr && !busy && needs_supply && !supply_q |=>
         state_q == fcsi_pkg::S_IDLE && stat_q[fcsi_pkg::IRQ_REJECT])
      else $error("erase or program started without supply");
   a_unknown_op: assert property (ctrl_wr && !busy && sw.wdata[3:0] > 4'h7 |=>
         (state_q == fcsi_pkg::S_IDLE) [*3])
      else $error("undefined operation started a cycle");
   a_poll_no_write: assert property (step_q == 2'd2 && op_q != fcsi_pkg::OP_READ_ID |->
         flash.we_n)
      else $error("write during status polling");
endmodule

//--- test/fcsi_flash_model.sv
/*
 Behavioural byte-wide flash: command latch, read modes and status word.
 Assumes the bench resolves the shared data wire into dq_in.
*/
`timescale 1ns/1ps
module fcsi_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
   parameter logic [7:0] PART_CODE  = 8'h3c, // Arbitrary value
   parameter int         BUSY_NS    = 2000
)(
   input  wire fcsi_pkg::fcsi_pins_s flash,
   input  wire logic [7:0]           dq_in,
   input  wire logic                 supply_high,
   input  wire logic                 fail,
   output logic [7:0]                dq
);
   logic [7:0] mem [256];
   logic [6:3] st = '0;
   logic [1:0] mode = '0;
   logic [1:0] setup = '0;
   logic [1:0] old;
   logic [3:0] blk;
   logic [7:0] out = '0;
   realtime    busy_until = 0;
   initial foreach (mem[i]) mem[i] = 8'hff;
   // Released wire shows the inverse of the last byte, never a held value
   assign dq = (!flash.ce_n && !flash.oe_n) ? out : ~out;
   // ==========================================================
   // Read latch: frozen at the falling enable edge
   always @(negedge flash.oe_n) begin
      case (mode)
         2'h0: out = mem[flash.addr[7:0]];
         2'h1: out = flash.addr[0] ? PART_CODE : MAKER_CODE;
         default: out = {$realtime >= busy_until, st, 3'h0};
      endcase
   end
   // ==========================================================
   // Command latch, taken at the rising write strobe
   always @(posedge flash.we_n) begin
      if (!flash.ce_n) begin
         old = setup;
         setup = 2'h0;
         if (old == 2'h1) begin
            if (!supply_high) st[3] = 1'b1;
            else if (fail) st[4] = 1'b1;
            else mem[flash.addr[7:0]] = mem[flash.addr[7:0]] & dq_in;
            busy_until = $realtime + BUSY_NS;
            mode = 2'h2;
         end else if (old == 2'h2 && dq_in == fcsi_pkg::CMD_CONFIRM) begin
            if (!supply_high) st[3] = 1'b1;
            else if (flash.addr[19:16] != blk) st[5] = 1'b1;
            else foreach (mem[i]) mem[i] = 8'hff;
            busy_until = $realtime + BUSY_NS;
            mode = 2'h2;
         end else begin
            blk = flash.addr[19:16];
            case (dq_in)
               fcsi_pkg::CMD_READ_ARRAY: mode = 2'h0;
               fcsi_pkg::CMD_READ_ID: mode = 2'h1;
               fcsi_pkg::CMD_READ_STATUS: mode = 2'h2;
               fcsi_pkg::CMD_CLEAR_STATUS: st[5:3] = '0;
               fcsi_pkg::CMD_PROG_SETUP: setup = 2'h1;
               fcsi_pkg::CMD_PROG_SETUP_2: setup = 2'h1;
               fcsi_pkg::CMD_ERASE_SETUP: setup = 2'h2;
               default: ;
            endcase
         end
      end
   end
endmodule

//--- test/fcsi_host_test.sv
/*
 Self-checking bench of the flash command host against the flash model.
 Assumes the package, host and model are compiled first.
*/
`timescale 1ns/1ps
module fcsi_host_test;
   typedef struct {
      logic [4:0] c;
      logic [7:0] a;
      logic [7:0] d;
      logic       s;
      logic [3:0] r;
      logic [31:0] e;
   } fcsi_row_s;
   logic                 clk_sys;
   logic                 rst;
   fcsi_pkg::fcsi_bus_s  sw;
   logic [31:0]          sw_rdata;
   logic                 irq;
   fcsi_pkg::fcsi_pins_s flash;
   logic [7:0]           dev_dq;
   logic                 supply_high_en;
   logic                 fail;
   logic [31:0]          v;
   int                   errors;
   int                   n_checks;
   wire logic [7:0]      dq_w = flash.dq_oe_n ? dev_dq : flash.dq_o;
   // ==========================================================
   // Rows: control, address, data, supply, register read back, value
   fcsi_row_s rows [8] = '{'{5'h01, 8'h00, 8'h00, 1'b0, 4'h4, 32'h3c5a},
      '{5'h07, 8'h05, 8'ha5, 1'b1, 4'h5, 32'h80}, '{5'h00, 8'h05, 8'h00, 1'b1, 4'h3, 32'ha5},
      '{5'h17, 8'h06, 8'h3c, 1'b1, 4'h5, 32'h80}, '{5'h00, 8'h06, 8'h00, 1'b1, 4'h3, 32'h3c},
      '{5'h04, 8'h05, 8'h00, 1'b1, 4'h5, 32'h80}, '{5'h00, 8'h05, 8'h00, 1'b1, 4'h3, 32'hff},
      '{5'h02, 8'h00, 8'h00, 1'b1, 4'h5, 32'h80}};
   fcsi_host fcsi_host_i (.clk_sys(clk_sys), .rst(rst), .sw(sw), .sw_rdata(sw_rdata),
      .irq(irq), .flash(flash), .flash_dq_in(dq_w), .supply_high_en(supply_high_en));
   fcsi_flash_model fcsi_flash_model_i (.flash(flash), .dq_in(dq_w),
      .supply_high(supply_high_en), .fail(fail), .dq(dev_dq));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      sw <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk_sys);
      sw.we <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      sw <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge clk_sys);
      sw.re <= 1'b0;
      #1 d = sw_rdata;
   endtask
   // One operation; wait on the interrupt, then read and clear its cause
   task automatic run(input logic [4:0] c, input logic [7:0] a, input logic [7:0] d,
      input logic s, input logic [2:0] ie);
      wr(fcsi_pkg::REG_SUPPLY, {31'h0, s});
      wr(fcsi_pkg::REG_ADDR, {24'h0, a});
      wr(fcsi_pkg::REG_DATA, {24'h0, d});
      wr(fcsi_pkg::REG_CTRL, {27'h0, c});
      for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk_sys);
      rd(fcsi_pkg::REG_IRQ_STAT, v);
      check(v, {29'h0, ie});
      check({31'h0, irq}, 32'h0);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========================================================
   // Sequence
   initial begin
      errors = 0;
      n_checks = 0;
      rst = 1'b1;
      fail = 1'b0;
      sw = '0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rd(fcsi_pkg::REG_STATUS, v);
      check(v, 32'h80);
      wr(fcsi_pkg::REG_CTRL, 32'h2);
      repeat (300) @(posedge clk_sys);
      check({31'h0, irq}, 32'h0);
      wr(fcsi_pkg::REG_IRQ_MASK, 32'h7);
      #1 check({31'h0, irq}, 32'h1);
      rd(fcsi_pkg::REG_IRQ_STAT, v);
      check(v, 32'h1);
      foreach (rows[i]) begin
         run(rows[i].c, rows[i].a, rows[i].d, rows[i].s, 3'h1);
         rd(rows[i].r, v);
         check(v, rows[i].e);
         $display("row %0d done", i);
      end
      // Low supply: the host refuses before touching the pins
      run(5'h07, 8'h07, 8'h00, 1'b0, 3'h4);
      fail <= 1'b1;
      run(5'h07, 8'h09, 8'h00, 1'b1, 3'h3);
      rd(fcsi_pkg::REG_STATUS, v);
      check(v, 32'h90);
      fail <= 1'b0;
      run(5'h02, 8'h00, 8'h00, 1'b1, 3'h1);
      rd(fcsi_pkg::REG_STATUS, v);
      check(v, 32'h90);
      run(5'h03, 8'h00, 8'h00, 1'b1, 3'h1);
      run(5'h02, 8'h00, 8'h00, 1'b1, 3'h1);
      rd(fcsi_pkg::REG_STATUS, v);
      check(v, 32'h80);
      // Undefined operation codes are refused like a missing supply
      run(5'h08, 8'h00, 8'h00, 1'b1, 3'h4);
      run(5'h0f, 8'h00, 8'h00, 1'b1, 3'h4);
      run(5'h05, 8'h00, 8'h00, 1'b1, 3'h1);
      run(5'h06, 8'h00, 8'h00, 1'b0, 3'h4);
      run(5'h06, 8'h00, 8'h00, 1'b1, 3'h1);
      rd(fcsi_pkg::REG_STATUS, v);
      check(v, 32'h80);
      $display("awkward cases done");
      test_done;
   end
   initial begin
      #2000000;
      errors++;
      $display("ERROR %0t watchdog expired", $time);
      test_done;
   end
endmodule
